// ==== rtl/uart_regs.vh ====
`ifndef UART_REGS_VH
`define UART_REGS_VH
// Register select codes
`define SEL_DATA        3'h0
`define SEL_INT_ENABLE  3'h1
`define SEL_INT_ID      3'h2
`define SEL_LINE_CTRL   3'h3
`define SEL_MODEM_CTRL  3'h4
`define SEL_LINE_STATUS 3'h5
`define SEL_MODEM_STAT  3'h6
`define SEL_SCRATCH     3'h7
// Line control fields
`define LC_STOP         2
`define LC_PAR_EN       3
`define LC_PAR_EVEN     4
`define LC_PAR_STICK    5
`define LC_BREAK        6
`define LC_DLAB         7
// Interrupt enable bits
`define IE_RX           0
`define IE_THR          1
`define IE_LINE         2
`define IE_MODEM        3
// Modem control bits
`define MC_TERM         0
`define MC_RTS          1
`define MC_GPA          2
`define MC_GPB          3
`define MC_LOOP         4
// Interrupt identification codes
`define IID_NONE        8'h01
`define IID_LINE        8'h06
`define IID_RX          8'h04
`define IID_THR         8'h02
`define IID_MODEM       8'h00
// Reset values
`define RST_BYTE        8'h00
`define RST_DIVISOR_LOW 8'h01
// Timing counts in sixteen times ticks
`define TICK_BIT_LAST   6'h0f
`define TICK_MID        6'h07
`define TICK_STOP_ONE   6'h0f
`define TICK_STOP_HALF  6'h17
`define TICK_STOP_TWO   6'h1f
`endif

// ==== rtl/baud_divider.v ====
`timescale 1ns/100ps
module baud_divider (
  // System
  input  wire        clock,
  input  wire        rst_n,
  // Divisor and outputs
  input  wire [15:0] divisor,
  output wire        baud_tick,
  output wire        baud_clock_out_n
);
  reg  [15:0] count_q;
  reg         baud_n_q;
  wire [15:0] last_count = divisor - 16'h0001;

  // Down counter; a zero divisor wraps to the longest period
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q  <= 16'h0000;
      baud_n_q <= 1'b1;
    end else begin
      if (count_q == 16'h0000)
        count_q <= last_count;
      else
        count_q <= count_q - 16'h0001;
      // Low in the upper half of the period; divisor one stays high
      baud_n_q <= (count_q > (last_count >> 1)) ? 1'b0 : 1'b1;
    end
  end

  assign baud_tick        = (count_q == 16'h0000);
  assign baud_clock_out_n = baud_n_q;
endmodule // baud_divider

// ==== rtl/rx_word_buffer.v ====
`timescale 1ns/100ps
module rx_word_buffer #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  // System
  input  wire             clock,
  input  wire             rst_n,
  // Filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0]   FULL    = DEPTH;
  localparam [AW-1:0] PTR_ONE = 1;
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push = in_valid & in_ready;
  wire            pop  = out_valid & out_ready;

  // Pointers and fill level
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_q <= wr_ptr_q + PTR_ONE;
      if (pop)
        rd_ptr_q <= rd_ptr_q + PTR_ONE;
      if (push & ~pop)
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
    end
  end

  // Storage needs no reset; the fill count guards it
  always @(posedge clock) begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

  assign in_ready  = (count_q != FULL);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_ptr_q];
endmodule // rx_word_buffer

// ==== rtl/async_serial_uart_with_modem_ctl.v ====
`timescale 1ns/100ps
`include "uart_regs.vh"
module async_serial_uart_with_modem_ctl (
  // System
  input  wire       clock,
  input  wire       rst_n,
  input  wire       master_reset,
  // Processor bus selects and strobes
  input  wire       select_in_a,
  input  wire       select_in_b,
  input  wire       select_in_c_n,
  input  wire       reg_select_0,
  input  wire       reg_select_1,
  input  wire       reg_select_2,
  input  wire       addr_latch_strobe_n,
  input  wire       rd,
  input  wire       rd_n,
  input  wire       wr,
  input  wire       wr_n,
  // Processor bus data
  input  wire [7:0] data_in,
  output wire [7:0] data_out,
  output wire       data_oe,
  output wire       selected_indicator,
  output wire       driver_disable,
  output wire       irq_out,
  // Clocks
  input  wire       rx_clock_in,
  output wire       baud_clock_out_n,
  // Serial line
  input  wire       serial_rx_line,
  output wire       serial_tx_line,
  // Modem handshake
  input  wire       clear_to_send_n,
  input  wire       data_set_ready_n,
  input  wire       ring_indicator_n,
  input  wire       carrier_detect_n,
  output wire       terminal_ready_n,
  output wire       request_to_send_n,
  output wire       gp_output_a_n,
  output wire       gp_output_b_n
);
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_START  = 3'h1;
  localparam [2:0] ST_DATA   = 3'h2;
  localparam [2:0] ST_PARITY = 3'h3;
  localparam [2:0] ST_STOP   = 3'h4;

  // Keep only the active character bits
  function [7:0] mask_len;
    input [7:0] value;
    input [1:0] len;
    begin
      mask_len = value & (8'hff >> (2'h3 - len));
    end
  endfunction

  // Parity bit for a character under the current format
  function par_bit;
    input [7:0] value;
    input       even;
    input       stick;
    begin
      par_bit = stick ? ~even : (^value) ^ ~even;
    end
  endfunction

  reg  [1:0]  rst_pipe_q;
  wire        rst_sync_n = rst_pipe_q[1];
  reg  [3:0]  latch_q;
  reg         read_prev_q;
  reg         write_prev_q;
  reg         rclk_prev_q;
  reg  [7:0]  data_out_q;
  reg         selected_q;
  reg         irq_q;
  reg  [7:0]  divisor_low_q;
  reg  [7:0]  divisor_latch_high_q;
  reg  [3:0]  interrupt_enable_reg_q;
  reg  [7:0]  line_control_q;
  reg  [4:0]  modem_control_reg_q;
  reg  [7:0]  scratch_q;
  reg  [7:0]  holding_q;
  reg         tx_holding_empty_q;
  reg         tx_holding_empty_int_q;
  reg  [2:0]  tx_state_q;
  reg  [7:0]  tx_shift_q;
  reg         tx_par_q;
  reg  [2:0]  tx_bitn_q;
  reg  [5:0]  tx_cnt_q;
  reg         serial_tx_q;
  reg  [2:0]  rx_state_q;
  reg  [7:0]  rx_shift_q;
  reg         rx_par_q;
  reg  [2:0]  rx_bitn_q;
  reg  [5:0]  rx_cnt_q;
  reg         rx_line_prev_q;
  reg         rx_push_q;
  reg  [7:0]  rx_word_q;
  reg  [3:0]  line_err_q;
  reg  [3:0]  modem_lvl_q;
  reg  [3:0]  modem_delta_q;
  reg  [7:0]  read_value;
  reg  [7:0]  int_id;

  // Release of reset and master reset through two flip-flops
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      rst_pipe_q <= 2'b00;
    else
      rst_pipe_q <= {rst_pipe_q[0], ~master_reset};
  end

  // Address strobe low passes selects, high holds them
  wire [3:0] live_sel = {select_in_a & select_in_b & ~select_in_c_n, reg_select_2, reg_select_1, reg_select_0};
  wire [3:0] eff_sel  = addr_latch_strobe_n ? latch_q : live_sel;
  wire       chip_sel = eff_sel[3];
  wire [2:0] sel      = eff_sel[2:0];
  wire       dlab     = line_control_q[`LC_DLAB];
  wire       loop     = modem_control_reg_q[`MC_LOOP];
  wire [1:0] len      = line_control_q[1:0];
  wire       read_act  = chip_sel & (rd | ~rd_n);
  wire       write_act = chip_sel & (wr | ~wr_n);
  wire       rd_start  = read_act & ~read_prev_q;
  wire       wr_start  = write_act & ~write_prev_q;
  wire       thr_write = wr_start & (sel == `SEL_DATA) & ~dlab;
  wire       rbr_read  = rd_start & (sel == `SEL_DATA) & ~dlab;
  wire       lsr_read  = rd_start & (sel == `SEL_LINE_STATUS);
  wire       msr_read  = rd_start & (sel == `SEL_MODEM_STAT);
  wire       iir_read  = rd_start & (sel == `SEL_INT_ID);
  wire       ier_write = wr_start & (sel == `SEL_INT_ENABLE) & ~dlab;
  wire       tx_tick;
  wire       rx_tick   = rx_clock_in & ~rclk_prev_q;
  wire       buf_ready;
  wire       buf_valid;
  wire [7:0] buf_data;
  wire       tx_idle   = (tx_state_q == ST_IDLE);

  // Bus front end: strobe edges, address latch, read data capture
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      latch_q      <= 4'h0;
      read_prev_q  <= 1'b0;
      write_prev_q <= 1'b0;
      rclk_prev_q  <= 1'b1; // Baud clock idles high, so no false tick
      data_out_q   <= `RST_BYTE;
      selected_q   <= 1'b0;
      irq_q        <= 1'b0;
    end else begin
      if (!addr_latch_strobe_n)
        latch_q <= live_sel;
      read_prev_q  <= read_act;
      write_prev_q <= write_act;
      rclk_prev_q  <= rx_clock_in;
      selected_q   <= chip_sel;
      irq_q        <= (int_id != `IID_NONE);
      // Captured once per strobe so a pop cannot change the byte shown
      if (rd_start)
        data_out_q <= read_value;
    end
  end

  // Configuration registers written by the processor
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      divisor_low_q          <= `RST_DIVISOR_LOW;
      divisor_latch_high_q   <= `RST_BYTE;
      interrupt_enable_reg_q <= 4'h0;
      line_control_q         <= `RST_BYTE;
      modem_control_reg_q    <= 5'h00;
      scratch_q              <= `RST_BYTE;
    end else if (wr_start) begin
      if (sel == `SEL_DATA && dlab)
        divisor_low_q <= data_in;
      else if (sel == `SEL_INT_ENABLE && dlab)
        divisor_latch_high_q <= data_in;
      else if (sel == `SEL_INT_ENABLE)
        interrupt_enable_reg_q <= data_in[3:0];
      else if (sel == `SEL_LINE_CTRL)
        line_control_q <= data_in;
      else if (sel == `SEL_MODEM_CTRL)
        modem_control_reg_q <= data_in[4:0];
      else if (sel == `SEL_SCRATCH)
        scratch_q <= data_in;
    end
  end

  // Transmit stop length in ticks
  wire [5:0] stop_last = ~line_control_q[`LC_STOP] ? `TICK_STOP_ONE :
                         (len == 2'h0) ? `TICK_STOP_HALF : `TICK_STOP_TWO;
  wire [2:0] bit_last  = 3'h4 + {1'b0, len};
  wire       tx_par_en = line_control_q[`LC_PAR_EN];

  // Transmitter: holding register, shifter and framing
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      holding_q          <= `RST_BYTE;
      tx_holding_empty_q <= 1'b1;
      tx_holding_empty_int_q         <= 1'b0;
      tx_state_q         <= ST_IDLE;
      tx_shift_q         <= `RST_BYTE;
      tx_par_q           <= 1'b0;
      tx_bitn_q          <= 3'h0;
      tx_cnt_q           <= 6'h00;
    end else begin
      if (thr_write) begin
        holding_q          <= mask_len(data_in, len);
        tx_holding_empty_q <= 1'b0;
      end
      // Set wins over clear for the empty interrupt
      if ((tx_tick && tx_idle && !tx_holding_empty_q && !thr_write) ||
          (ier_write && data_in[`IE_THR] && !interrupt_enable_reg_q[`IE_THR] && tx_holding_empty_q))
        tx_holding_empty_int_q <= 1'b1;
      else if (thr_write || (iir_read && int_id == `IID_THR))
        tx_holding_empty_int_q <= 1'b0;
      if (tx_tick) begin
        tx_cnt_q <= tx_cnt_q + 6'h01;
        case (tx_state_q)
          ST_IDLE: begin
            tx_cnt_q <= 6'h00;
            if (!tx_holding_empty_q && !thr_write) begin
              tx_shift_q         <= holding_q;
              tx_par_q           <= par_bit(holding_q, line_control_q[`LC_PAR_EVEN], line_control_q[`LC_PAR_STICK]);
              tx_holding_empty_q <= 1'b1;
              tx_state_q         <= ST_START;
            end
          end
          ST_START: begin
            if (tx_cnt_q == `TICK_BIT_LAST) begin
              tx_cnt_q   <= 6'h00;
              tx_bitn_q  <= 3'h0;
              tx_state_q <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (tx_cnt_q == `TICK_BIT_LAST) begin
              tx_cnt_q   <= 6'h00;
              tx_shift_q <= tx_shift_q >> 1;
              tx_bitn_q  <= tx_bitn_q + 3'h1;
              if (tx_bitn_q == bit_last)
                tx_state_q <= tx_par_en ? ST_PARITY : ST_STOP;
            end
          end
          ST_PARITY: begin
            if (tx_cnt_q == `TICK_BIT_LAST) begin
              tx_cnt_q   <= 6'h00;
              tx_state_q <= ST_STOP;
            end
          end
          default: begin
            if (tx_cnt_q >= stop_last) begin
              tx_cnt_q   <= 6'h00;
              tx_state_q <= ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Line level for the current transmit state
  reg tx_level;
  always @* begin
    case (tx_state_q)
      ST_START:  tx_level = 1'b0;
      ST_DATA:   tx_level = tx_shift_q[0];
      ST_PARITY: tx_level = tx_par_q;
      default:   tx_level = 1'b1;
    endcase
  end

  // Serial output: break forces space, loopback keeps mark on the pin
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n)
      serial_tx_q <= 1'b1;
    else
      serial_tx_q <= tx_level & ~line_control_q[`LC_BREAK];
  end

  // Receiver input; carrier detect is deliberately not involved
  wire rx_line = loop ? serial_tx_q : serial_rx_line;

  // Receiver: start search, mid bit confirm, centre sampling
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_state_q     <= ST_IDLE;
      rx_shift_q     <= `RST_BYTE;
      rx_par_q       <= 1'b0;
      rx_bitn_q      <= 3'h0;
      rx_cnt_q       <= 6'h00;
      rx_line_prev_q <= 1'b1;
      rx_push_q      <= 1'b0;
      rx_word_q      <= `RST_BYTE;
      line_err_q     <= 4'h0;
    end else begin
      rx_push_q <= 1'b0;
      // Error flags: a new error in the read cycle is kept
      if (lsr_read)
        line_err_q <= 4'h0;
      if (rx_push_q && !buf_ready)
        line_err_q[0] <= 1'b1;
      if (rx_tick) begin
        rx_line_prev_q <= rx_line;
        rx_cnt_q       <= rx_cnt_q + 6'h01;
        case (rx_state_q)
          ST_IDLE: begin
            rx_cnt_q <= 6'h00;
            if (rx_line_prev_q && !rx_line) begin
              rx_shift_q <= `RST_BYTE;
              rx_state_q <= ST_START;
            end
          end
          ST_START: begin
            if (rx_cnt_q == `TICK_MID) begin
              rx_cnt_q   <= 6'h00;
              rx_bitn_q  <= 3'h0;
              rx_state_q <= rx_line ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (rx_cnt_q == `TICK_BIT_LAST) begin
              rx_cnt_q              <= 6'h00;
              rx_shift_q[rx_bitn_q] <= rx_line;
              rx_bitn_q             <= rx_bitn_q + 3'h1;
              if (rx_bitn_q == bit_last)
                rx_state_q <= tx_par_en ? ST_PARITY : ST_STOP;
            end
          end
          ST_PARITY: begin
            if (rx_cnt_q == `TICK_BIT_LAST) begin
              rx_cnt_q   <= 6'h00;
              rx_par_q   <= rx_line;
              rx_state_q <= ST_STOP;
              if (rx_line != par_bit(rx_shift_q, line_control_q[`LC_PAR_EVEN], line_control_q[`LC_PAR_STICK]))
                line_err_q[1] <= 1'b1;
            end
          end
          default: begin
            if (rx_cnt_q == `TICK_BIT_LAST) begin
              rx_cnt_q   <= 6'h00;
              rx_state_q <= ST_IDLE;
              rx_push_q  <= 1'b1;
              rx_word_q  <= mask_len(rx_shift_q, len);
              if (!rx_line)
                line_err_q[2] <= 1'b1;
              if (!rx_line && rx_shift_q == 8'h00 && !(tx_par_en && rx_par_q))
                line_err_q[3] <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Modem input levels, loopback takes them from the control bits
  wire [3:0] modem_now = loop ? {modem_control_reg_q[`MC_GPB], modem_control_reg_q[`MC_GPA],
                                 modem_control_reg_q[`MC_TERM], modem_control_reg_q[`MC_RTS]} :
                                {~carrier_detect_n, ~ring_indicator_n, ~data_set_ready_n, ~clear_to_send_n};
  wire [3:0] delta_set = {modem_now[3] ^ modem_lvl_q[3],
                          modem_lvl_q[2] & ~modem_now[2],
                          modem_now[1] ^ modem_lvl_q[1],
                          modem_now[0] ^ modem_lvl_q[0]};

  // Modem status: levels and change flags, set wins over read clear
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      modem_lvl_q   <= 4'h0;
      modem_delta_q <= 4'h0;
    end else begin
      modem_lvl_q   <= modem_now;
      modem_delta_q <= (msr_read ? 4'h0 : modem_delta_q) | delta_set;
    end
  end

  wire [7:0] line_status = {1'b0, tx_holding_empty_q & tx_idle, tx_holding_empty_q, line_err_q, buf_valid};

  // Interrupt priority: line errors, data, holding empty, modem
  always @* begin
    if (interrupt_enable_reg_q[`IE_LINE] && line_err_q != 4'h0)
      int_id = `IID_LINE;
    else if (interrupt_enable_reg_q[`IE_RX] && buf_valid)
      int_id = `IID_RX;
    else if (interrupt_enable_reg_q[`IE_THR] && tx_holding_empty_int_q)
      int_id = `IID_THR;
    else if (interrupt_enable_reg_q[`IE_MODEM] && modem_delta_q != 4'h0)
      int_id = `IID_MODEM;
    else
      int_id = `IID_NONE;
  end

  // Read data selection
  always @* begin
    if (sel == `SEL_DATA)
      read_value = dlab ? divisor_low_q : buf_data;
    else if (sel == `SEL_INT_ENABLE)
      read_value = dlab ? divisor_latch_high_q : {4'h0, interrupt_enable_reg_q};
    else if (sel == `SEL_INT_ID)
      read_value = int_id;
    else if (sel == `SEL_LINE_CTRL)
      read_value = line_control_q;
    else if (sel == `SEL_MODEM_CTRL)
      read_value = {3'h0, modem_control_reg_q};
    else if (sel == `SEL_LINE_STATUS)
      read_value = line_status;
    else if (sel == `SEL_MODEM_STAT)
      read_value = {modem_lvl_q, modem_delta_q};
    else
      read_value = scratch_q;
  end

  // Baud generator for the transmitter
  baud_divider u_baud_divider (
    .clock            (clock),
    .rst_n            (rst_sync_n),
    .divisor          ({divisor_latch_high_q, divisor_low_q}),
    .baud_tick        (tx_tick),
    .baud_clock_out_n (baud_clock_out_n)
  );

  // Two received words ride out a slow reader
  rx_word_buffer #(.WIDTH(8), .DEPTH(2), .AW(1)) u_rx_word_buffer (
    .clock     (clock),
    .rst_n     (rst_sync_n),
    .in_valid  (rx_push_q),
    .in_ready  (buf_ready),
    .in_data   (rx_word_q),
    .out_valid (buf_valid),
    .out_ready (rbr_read),
    .out_data  (buf_data)
  );

  // Pin outputs
  assign data_out           = data_out_q;
  assign data_oe            = read_act;
  assign driver_disable     = ~read_act;
  assign selected_indicator = selected_q;
  assign irq_out            = irq_q;
  assign serial_tx_line     = serial_tx_q | loop;
  assign terminal_ready_n   = ~modem_control_reg_q[`MC_TERM];
  assign request_to_send_n  = ~modem_control_reg_q[`MC_RTS];
  assign gp_output_a_n      = ~(modem_control_reg_q[`MC_GPA] & ~loop);
  assign gp_output_b_n      = ~(modem_control_reg_q[`MC_GPB] & ~loop);
endmodule // async_serial_uart_with_modem_ctl

// ==== verification/far_modem.sv ====
`timescale 1ns/100ps
// Far end of the line: echoes the line back and holds the modem pins
module far_modem (
  // Serial line
  input  wire       serial_tx_line,
  output wire       serial_rx_line,
  // Modem pin levels chosen by the bench
  input  wire [3:0] levels,
  output wire       clear_to_send_n,
  output wire       data_set_ready_n,
  output wire       ring_indicator_n,
  output wire       carrier_detect_n
);
  // Echo keeps mark while idle, so the receiver never sees a floating line
  assign serial_rx_line = serial_tx_line;
  assign {carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n} = levels;
endmodule // far_modem

// ==== verification/uart_sva.sv ====
`timescale 1ns/100ps
module uart_sva (
  // System
  input wire       clock,
  input wire       rst_n,
  input wire       master_reset,
  // Bus
  input wire       select_in_a,
  input wire       select_in_b,
  input wire       select_in_c_n,
  input wire       rd,
  input wire       rd_n,
  input wire       wr,
  input wire       wr_n,
  input wire [7:0] data_out,
  input wire       data_oe,
  input wire       selected_indicator,
  input wire       driver_disable,
  input wire       irq_out,
  // Line and modem
  input wire       serial_tx_line,
  input wire       terminal_ready_n,
  input wire       request_to_send_n,
  input wire       gp_output_a_n,
  input wire       gp_output_b_n
);
  // Selected chip and strobes; address strobe is tied low
  wire cs = select_in_a & select_in_b & ~select_in_c_n;
  wire rs = rd | ~rd_n;
  wire ws = wr | ~wr_n;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_oe; data_oe == (cs & rs); endproperty
  a_oe: assert property (p_oe) else $error("data enable wrong");
  property p_dd; driver_disable == !data_oe; endproperty
  a_dd: assert property (p_dd) else $error("driver disable wrong");
  property p_sel; $stable(cs) |-> selected_indicator == cs; endproperty
  a_sel: assert property (p_sel) else $error("select indicator wrong");
  property p_mr; master_reset[*5] |-> serial_tx_line && !irq_out && data_out == 8'h00; endproperty
  a_mr: assert property (p_mr) else $error("master reset not idle");
  property p_mo; master_reset[*5] |-> &{terminal_ready_n, request_to_send_n, gp_output_a_n, gp_output_b_n}; endproperty
  a_mo: assert property (p_mo) else $error("modem outputs not high");
  property p_tx; $fell(serial_tx_line) |=> (!serial_tx_line)[*7]; endproperty
  a_tx: assert property (p_tx) else $error("start bit too short");
  property p_hold; (!data_oe && !master_reset)[*5] |-> $stable(data_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_dtr; $fell(terminal_ready_n) |-> $past(ws & cs) || $past(ws & cs, 2); endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready without write");
endmodule // uart_sva
bind async_serial_uart_with_modem_ctl uart_sva i_sva (.clock, .rst_n, .master_reset, .select_in_a, .select_in_b,
  .select_in_c_n, .rd, .rd_n, .wr, .wr_n, .data_out, .data_oe, .selected_indicator, .driver_disable, .irq_out,
  .serial_tx_line, .terminal_ready_n, .request_to_send_n, .gp_output_a_n, .gp_output_b_n);

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module testbench;
  // Bench drive and bookkeeping
  logic       clock, rst_n, master_reset, sel_a, rd, rd_n, wr, wr_n, hi, cs;
  logic [2:0] rsel;
  logic [7:0] data_in, rdat;
  logic [3:0] levels;
  int         fails, num_checks, n;
  time        t0;
  // Design outputs and far-end wires
  wire [7:0]  data_out;
  wire        data_oe, driver_disable, irq_out, baud_n, serial_rx_line, serial_tx_line;
  wire        clear_to_send_n, data_set_ready_n, ring_indicator_n, carrier_detect_n;
  wire        terminal_ready_n, request_to_send_n, gp_output_a_n, gp_output_b_n;
  async_serial_uart_with_modem_ctl i_dut (.clock, .rst_n, .master_reset, .select_in_a(sel_a), .select_in_b(1'b1),
    .select_in_c_n(1'b0), .reg_select_0(rsel[0]), .reg_select_1(rsel[1]), .reg_select_2(rsel[2]),
    .addr_latch_strobe_n(1'b0), .rd, .rd_n, .wr, .wr_n, .data_in, .data_out, .data_oe, .selected_indicator(),
    .driver_disable, .irq_out, .rx_clock_in(baud_n), .baud_clock_out_n(baud_n), .serial_rx_line,
    .serial_tx_line, .clear_to_send_n, .data_set_ready_n, .ring_indicator_n, .carrier_detect_n,
    .terminal_ready_n, .request_to_send_n, .gp_output_a_n, .gp_output_b_n);
  far_modem i_far (.serial_tx_line, .serial_rx_line, .levels, .clear_to_send_n, .data_set_ready_n,
    .ring_indicator_n, .carrier_detect_n);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // One access; hi picks the active-high or active-low strobe, idle cycle after
  task acc(input bit w, input [2:0] a, input [7:0] d);
    begin
      @(posedge clock);
      rsel <= a; data_in <= d; sel_a <= cs;
      if (w) begin wr <= hi; wr_n <= hi; end else begin rd <= hi; rd_n <= hi; end
      #1 if (!w && cs) `CHK(driver_disable, 1'b0)
      @(posedge clock);
      rd <= 1'b0; wr <= 1'b0; rd_n <= 1'b1; wr_n <= 1'b1; sel_a <= 1'b0;
      @(posedge clock);
      #1 rdat = data_out;
      `CHK(data_oe, 1'b0)
    end
  endtask
  task wrr(input [2:0] a, input [7:0] d); acc(1'b1, a, d); endtask
  task rdc(input [2:0] a, input [7:0] e); begin acc(1'b0, a, 8'h00); `CHK(rdat, e) end endtask
  // Follow one frame at bit centres; divisor 3 gives 48 clocks a bit
  // Sampled on falling clock edges, where the line has settled
  task frame(input int nb, input [8:0] v);
    begin
      n = 0;
      while (serial_tx_line === 1'b1 && n < 2000) begin @(negedge clock); n++; end
      repeat (24) @(negedge clock);
      `CHK(serial_tx_line, 1'b0)
      for (int i = 0; i < nb; i++) begin repeat (48) @(negedge clock); `CHK(serial_tx_line, v[i]) end
      repeat (48) @(negedge clock);
      `CHK(serial_tx_line, 1'b1)
    end
  endtask
  task print_verdict;
    begin
      if (fails == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    print_verdict;
  end
  initial begin
    {master_reset, sel_a, rd, wr, rsel, data_in} = 0; {rd_n, wr_n, hi, cs} = 4'hf; levels = 4'hf;
    fails = 0; num_checks = 0; rst_n = 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rdc(5, 8'h60);
    // Deselected write is lost; low strobes work too
    cs = 1'b0; wrr(7, 8'h5a); cs = 1'b1;
    rdc(7, 8'h00);
    hi = 1'b0; wrr(7, 8'h5a); rdc(7, 8'h5a); hi = 1'b1;
    wrr(4, 8'h0f);
    `CHK({terminal_ready_n, request_to_send_n, gp_output_a_n, gp_output_b_n}, 4'h0)
    // Loopback: control bits seen as status, clear-to-send pin ignored
    wrr(4, 8'h1f);
    `CHK({terminal_ready_n, request_to_send_n, gp_output_a_n, gp_output_b_n}, 4'h3)
    acc(1'b0, 6, 8'h00); `CHK(rdat[7:4], 4'hf)
    wrr(4, 8'h00); acc(1'b0, 6, 8'h00); wrr(1, 8'h08);
    @(posedge clock) levels <= 4'h0;
    repeat (6) @(posedge clock);
    `CHK(irq_out, 1'b1)
    rdc(6, 8'hfb);
    `CHK(irq_out, 1'b0)
    rdc(6, 8'hf0);
    @(posedge clock) levels <= 4'h4;
    repeat (6) @(posedge clock);
    `CHK(irq_out, 1'b1)
    rdc(6, 8'hb4);
    wrr(1, 8'h00);
    @(posedge clock) levels <= 4'hf;
    // Divisor 3, eight bits, one stop
    wrr(3, 8'h80); wrr(0, 8'h03); wrr(1, 8'h00); wrr(3, 8'h03);
    @(negedge baud_n) t0 = $time;
    @(negedge baud_n) `CHK($time - t0, 60)
    // Three words unread: two buffered, third refused
    for (int k = 0; k < 3; k++) begin wrr(0, 8'ha5 + k); frame(8, 8'ha5 + k); end
    repeat (48) @(posedge clock);
    rdc(5, 8'h63);
    rdc(0, 8'ha5); rdc(0, 8'ha6); rdc(5, 8'h60);
    // Five bits: upper bits dropped and read as zero
    wrr(3, 8'h00); wrr(0, 8'hff); frame(5, 8'hff);
    repeat (48) @(posedge clock);
    rdc(0, 8'h1f);
    // Eight bits, even parity, two stops: still sending in the second stop
    wrr(3, 8'h1f); wrr(0, 8'h5b); frame(9, 9'h15b);
    repeat (24) @(posedge clock);
    rdc(5, 8'h21);
    rdc(0, 8'h5b);
    wrr(4, 8'h0f);
    @(posedge clock) master_reset <= 1'b1;
    repeat (6) @(posedge clock);
    `CHK({terminal_ready_n, request_to_send_n, gp_output_a_n, gp_output_b_n, serial_tx_line}, 5'h1f)
    master_reset <= 1'b0;
    repeat (3) @(posedge clock);
    rdc(5, 8'h60);
    // Holding empty interrupt: raised on enable, cleared by identification read
    wrr(1, 8'h02);
    `CHK(irq_out, 1'b1)
    rdc(2, 8'h02);
    rdc(2, 8'h01);
    print_verdict;
  end
endmodule // testbench
